// ### wsap_defines.svh
`ifndef WSAP_DEFINES_SVH
`define WSAP_DEFINES_SVH

// register locations reached through the pointer
`define WSAP_OFS_MODE 7'h00
`define WSAP_OFS_BCAST 7'h3e
`define WSAP_OFS_GRP1 7'h3f
`define WSAP_OFS_GRP2 7'h40
`define WSAP_OFS_GRP3 7'h41

// unused holes in the map; the top is WSAP_ALL_HI
`define WSAP_HOLE1_LO 7'h06
`define WSAP_HOLE1_HI 7'h07
`define WSAP_HOLE2_LO 7'h1a
`define WSAP_HOLE2_HI 7'h21

// step range windows
`define WSAP_ALL_LO 7'h00
`define WSAP_ALL_HI 7'h41
`define WSAP_BRT_LO 7'h0a
`define WSAP_BRT_HI 7'h19
`define WSAP_CTL_LO 7'h00
`define WSAP_CTL_HI 7'h31
`define WSAP_GRB_LO 7'h08
`define WSAP_GRB_HI 7'h19

// first mode config fields
`define WSAP_MODE_SEL_LO 5
`define WSAP_MODE_SEL_HI 6
`define WSAP_MODE_EN_BCAST 0
`define WSAP_MODE_EN_GRP3 1
`define WSAP_MODE_EN_GRP2 2
`define WSAP_MODE_EN_GRP1 3

// reset values
`define WSAP_CTRL_RST 8'h80
`define WSAP_MODE_RST 8'h09
`define WSAP_BCAST_RST 8'he0
`define WSAP_GRP_RST 8'hec

// serial framing
`define WSAP_LAST_BIT 4'h7
`define WSAP_ACK_BIT 4'h8
`define WSAP_ACK_WAIT 200

`endif

// ### wsap_pkg.sv
package wsap_pkg;

	typedef enum logic [4:0] {
		WSAP_ST_IDLE = 5'h01,
		WSAP_ST_ADDR = 5'h02,
		WSAP_ST_CTRL = 5'h04,
		WSAP_ST_DATA = 5'h08,
		WSAP_ST_SKIP = 5'h10
	} wsap_state_t;

endpackage

// ### wsap_top.sv
`include "wsap_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module wsap_top #(
	parameter logic [2:0] ADDR_HI = 3'h5 // fixed upper bits, arbitrary value
)(
	// system
	input wire logic mclk,
	input wire logic reset,
	input wire logic reset_pin_n,
	// serial link
	input wire logic fast_serial_clock_line,
	input wire logic fast_serial_data_line,
	output logic sda_out,
	output logic sda_oe_n,
	// address select pins
	input wire logic addr_select_pin_0,
	input wire logic addr_select_pin_1,
	input wire logic addr_select_pin_2,
	input wire logic addr_select_pin_3,
	// register write port
	output logic reg_wr_stb,
	output logic [6:0] reg_wr_addr,
	output logic [7:0] reg_wr_data,
	output logic [7:0] pointer_control
);

	// link domain: one sampled bit and a toggle per clock rise
	logic link_bit_ff = 1'b0;
	logic link_tgl_ff = 1'b0;

	always_ff @(posedge fast_serial_clock_line)
	begin
		link_bit_ff <= fast_serial_data_line;
		link_tgl_ff <= ~link_tgl_ff;
	end

	// synchronisers into mclk
	logic [2:0] scl_sync_ff, sda_sync_ff, tgl_sync_ff;
	logic [1:0] rstn_sync_ff;
	logic [3:0] pins_s1_ff, pins_s2_ff;
	wire [3:0] pins_raw = {addr_select_pin_3, addr_select_pin_2,
		addr_select_pin_1, addr_select_pin_0};

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
			tgl_sync_ff <= 3'h0;
			rstn_sync_ff <= 2'h0;
			pins_s1_ff <= 4'h0;
			pins_s2_ff <= 4'h0;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[1:0], fast_serial_clock_line};
			sda_sync_ff <= {sda_sync_ff[1:0], fast_serial_data_line};
			tgl_sync_ff <= {tgl_sync_ff[1:0], link_tgl_ff};
			rstn_sync_ff <= {rstn_sync_ff[0], reset_pin_n};
			pins_s1_ff <= pins_raw;
			pins_s2_ff <= pins_s1_ff;
		end
	end

	// pin reset held low resets the block like the system reset
	wire rst_all = reset | ~rstn_sync_ff[1];

	// bus conditions, all taken from second and third stages
	wire scl_hi = scl_sync_ff[1] & scl_sync_ff[2];
	wire scl_fall = scl_sync_ff[2] & ~scl_sync_ff[1];
	wire bus_start = scl_hi & sda_sync_ff[2] & ~sda_sync_ff[1];
	wire bus_stop = scl_hi & ~sda_sync_ff[2] & sda_sync_ff[1];
	wire bit_evt = tgl_sync_ff[1] ^ tgl_sync_ff[2];

	// state
	wsap_pkg::wsap_state_t state_ff, nxt_state;
	logic [3:0] cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] ctrl_ff, mode_ff, bcast_ff, grp1_ff, grp2_ff, grp3_ff;
	logic ack_pend_ff, ack_on_ff, sda_oe_n_ff;
	logic wr_stb_ff;
	logic [6:0] wr_addr_ff;
	logic [7:0] wr_data_ff;

	function automatic logic addr_hit(input logic [6:0] a,
		input logic [7:0] r, input logic en);
		addr_hit = en & (a == r[7:1]);
	endfunction

	function automatic logic loc_used(input logic [6:0] p);
		loc_used = !((p >= `WSAP_HOLE1_LO && p <= `WSAP_HOLE1_HI) ||
			(p >= `WSAP_HOLE2_LO && p <= `WSAP_HOLE2_HI) ||
			(p > `WSAP_ALL_HI));
	endfunction

	function automatic logic [6:0] step_ptr(input logic [6:0] p,
		input logic [2:0] m);
		unique case (m)
			3'h4: step_ptr = (p == `WSAP_ALL_HI) ? `WSAP_ALL_LO : p + 7'h01;
			3'h5: step_ptr = (p == `WSAP_BRT_HI) ? `WSAP_BRT_LO : p + 7'h01;
			3'h6: step_ptr = (p == `WSAP_CTL_HI) ? `WSAP_CTL_LO : p + 7'h01;
			3'h7: step_ptr = (p == `WSAP_GRB_HI) ? `WSAP_GRB_LO : p + 7'h01;
			// fixed pointer; reserved codes also hold still
			default: step_ptr = p;
		endcase
	endfunction

	// byte assembly
	wire [7:0] nxt_shift = {shift_ff[6:0], link_bit_ff};
	wire in_frame = (state_ff != wsap_pkg::WSAP_ST_IDLE);
	wire byte_evt = bit_evt & ~bus_start & ~bus_stop & in_frame &
		(cnt_ff == `WSAP_LAST_BIT);
	wire addr_done = byte_evt & (state_ff == wsap_pkg::WSAP_ST_ADDR);
	wire ctrl_done = byte_evt & (state_ff == wsap_pkg::WSAP_ST_CTRL);
	wire data_done = byte_evt & (state_ff == wsap_pkg::WSAP_ST_DATA);

	// address decode
	wire [6:0] own_addr = {ADDR_HI, pins_s2_ff};
	wire [6:0] rx_addr = nxt_shift[7:1];
	wire rx_write = ~nxt_shift[0];
	wire any_hit = addr_hit(rx_addr, {own_addr, 1'b0}, 1'b1) |
		addr_hit(rx_addr, bcast_ff, mode_ff[`WSAP_MODE_EN_BCAST]) |
		addr_hit(rx_addr, grp1_ff, mode_ff[`WSAP_MODE_EN_GRP1]) |
		addr_hit(rx_addr, grp2_ff, mode_ff[`WSAP_MODE_EN_GRP2]) |
		addr_hit(rx_addr, grp3_ff, mode_ff[`WSAP_MODE_EN_GRP3]);
	wire addr_ok = any_hit & rx_write;

	// pointer and stepping
	wire [6:0] ptr = ctrl_ff[6:0];
	wire [2:0] step_sel = {ctrl_ff[7], mode_ff[`WSAP_MODE_SEL_HI],
		mode_ff[`WSAP_MODE_SEL_LO]};
	wire [6:0] nxt_ptr = step_ptr(ptr, step_sel);
	wire ptr_used = loc_used(ptr);
	wire wr_ok = data_done & ptr_used;

	// next state
	always_comb
	begin
		nxt_state = state_ff;
		if (bus_start)
			nxt_state = wsap_pkg::WSAP_ST_ADDR;
		else if (bus_stop)
			nxt_state = wsap_pkg::WSAP_ST_IDLE;
		else if (addr_done)
			nxt_state = addr_ok ? wsap_pkg::WSAP_ST_CTRL
				: wsap_pkg::WSAP_ST_SKIP;
		else if (ctrl_done)
			nxt_state = wsap_pkg::WSAP_ST_DATA;
	end

	wire [3:0] nxt_cnt = (cnt_ff == `WSAP_ACK_BIT) ? 4'h0 : cnt_ff + 4'h1;

	always_ff @(posedge mclk)
	begin
		if (rst_all)
		begin
			state_ff <= wsap_pkg::WSAP_ST_IDLE;
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			if (bus_start)
				cnt_ff <= 4'h0;
			else if (bit_evt & in_frame)
			begin
				cnt_ff <= nxt_cnt;
				if (cnt_ff != `WSAP_ACK_BIT)
					shift_ff <= nxt_shift;
			end
		end
	end

	// control byte, stepping and local address registers
	always_ff @(posedge mclk)
	begin
		if (rst_all)
		begin
			ctrl_ff <= `WSAP_CTRL_RST;
			mode_ff <= `WSAP_MODE_RST;
			bcast_ff <= `WSAP_BCAST_RST;
			grp1_ff <= `WSAP_GRP_RST;
			grp2_ff <= `WSAP_GRP_RST;
			grp3_ff <= `WSAP_GRP_RST;
		end
		else if (ctrl_done)
			ctrl_ff <= nxt_shift;
		else if (data_done)
		begin
			ctrl_ff[6:0] <= nxt_ptr;
			if (ptr == `WSAP_OFS_MODE)
				mode_ff <= nxt_shift;
			if (ptr == `WSAP_OFS_BCAST)
				bcast_ff <= nxt_shift;
			if (ptr == `WSAP_OFS_GRP1)
				grp1_ff <= nxt_shift;
			if (ptr == `WSAP_OFS_GRP2)
				grp2_ff <= nxt_shift;
			if (ptr == `WSAP_OFS_GRP3)
				grp3_ff <= nxt_shift;
		end
	end

	// write port toward the register bank
	always_ff @(posedge mclk)
	begin
		if (rst_all)
		begin
			wr_stb_ff <= 1'b0;
			wr_addr_ff <= 7'h00;
			wr_data_ff <= 8'h00;
		end
		else
		begin
			wr_stb_ff <= wr_ok;
			if (wr_ok)
			begin
				wr_addr_ff <= ptr;
				wr_data_ff <= nxt_shift;
			end
		end
	end

	// acknowledge: drive low from the fall after the eighth bit
	// to the fall after the ninth; the master's clock low time
	// must exceed the synchroniser delay of about three mclk
	wire ack_due = (addr_done & addr_ok) | ctrl_done | data_done;

	always_ff @(posedge mclk)
	begin
		if (rst_all | bus_stop | bus_start)
		begin
			ack_pend_ff <= 1'b0;
			ack_on_ff <= 1'b0;
			sda_oe_n_ff <= 1'b1;
		end
		else if (ack_due)
			ack_pend_ff <= 1'b1;
		else if (scl_fall & ack_pend_ff)
		begin
			ack_pend_ff <= 1'b0;
			ack_on_ff <= 1'b1;
			sda_oe_n_ff <= 1'b0;
		end
		else if (scl_fall & ack_on_ff)
		begin
			ack_on_ff <= 1'b0;
			sda_oe_n_ff <= 1'b1;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = sda_oe_n_ff;
	assign reg_wr_stb = wr_stb_ff;
	assign reg_wr_addr = wr_addr_ff;
	assign reg_wr_data = wr_data_ff;
	assign pointer_control = ctrl_ff;

	localparam int ACK_WAIT = `WSAP_ACK_WAIT;
	logic init_seen_ff;

	always_ff @(posedge mclk)
	begin
		if (rst_all)
			init_seen_ff <= 1'b0;
		else
			init_seen_ff <= 1'b1;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst_all);

	property p_reset_vals;
		!init_seen_ff |-> ctrl_ff == `WSAP_CTRL_RST &&
			bcast_ff == `WSAP_BCAST_RST && grp1_ff == `WSAP_GRP_RST &&
			grp2_ff == `WSAP_GRP_RST && grp3_ff == `WSAP_GRP_RST &&
			mode_ff[`WSAP_MODE_EN_GRP1] && mode_ff[`WSAP_MODE_EN_BCAST] &&
			!mode_ff[`WSAP_MODE_EN_GRP2] && !mode_ff[`WSAP_MODE_EN_GRP3];
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong");

	sequence s_read_addr;
		addr_done && nxt_shift[0];
	endsequence
	property p_read_nak;
		s_read_addr |=> sda_oe_n [*8];
	endproperty
	a_read_nak: assert property (p_read_nak)
		else $error("read address acknowledged");

	sequence s_write_match;
		addr_done && addr_ok;
	endsequence
	property p_ack_match;
		s_write_match |-> ##[1:ACK_WAIT] !sda_oe_n;
	endproperty
	a_ack_match: assert property (p_ack_match)
		else $error("no acknowledge for matching write");

	property p_ctrl_store;
		ctrl_done |=> ctrl_ff == $past(nxt_shift);
	endproperty
	a_ctrl_store: assert property (p_ctrl_store)
		else $error("control byte not stored");

	property p_hold;
		data_done && step_sel == 3'h0 |=> ptr == $past(ptr);
	endproperty
	a_hold: assert property (p_hold)
		else $error("pointer moved with stepping off");

	property p_step;
		data_done && step_sel == 3'h4 && ptr != `WSAP_ALL_HI
			|=> ptr == $past(ptr) + 7'h01;
	endproperty
	a_step: assert property (p_step)
		else $error("pointer did not advance");

	property p_wrap_all;
		data_done && step_sel == 3'h4 && ptr == `WSAP_ALL_HI
			|=> ptr == `WSAP_ALL_LO;
	endproperty
	a_wrap_all: assert property (p_wrap_all)
		else $error("full range wrap wrong");

	property p_wrap_brt;
		data_done && step_sel == 3'h5 && ptr == `WSAP_BRT_HI
			|=> ptr == `WSAP_BRT_LO;
	endproperty
	a_wrap_brt: assert property (p_wrap_brt)
		else $error("brightness wrap wrong");

	property p_wrap_ctl;
		data_done && step_sel == 3'h6 && ptr == `WSAP_CTL_HI
			|=> ptr == `WSAP_CTL_LO;
	endproperty
	a_wrap_ctl: assert property (p_wrap_ctl)
		else $error("control range wrap wrong");

	property p_wrap_grb;
		data_done && step_sel == 3'h7 && ptr == `WSAP_GRB_HI
			|=> ptr == `WSAP_GRB_LO;
	endproperty
	a_wrap_grb: assert property (p_wrap_grb)
		else $error("group range wrap wrong");

	property p_flag_keep;
		data_done |=> $stable(ctrl_ff[7]);
	endproperty
	a_flag_keep: assert property (p_flag_keep)
		else $error("step flag changed by stepping");

	property p_drop;
		data_done && !ptr_used |=> !reg_wr_stb;
	endproperty
	a_drop: assert property (p_drop)
		else $error("write to unused location issued");

	property p_write;
		data_done && ptr_used |=> reg_wr_stb &&
			reg_wr_addr == $past(ptr) && reg_wr_data == $past(nxt_shift);
	endproperty
	a_write: assert property (p_write)
		else $error("write not issued at pointer");

endmodule // wsap_top

`default_nettype wire

// ### wsap_master_model.sv
`timescale 1ns/1ns
`default_nettype none

module wsap_master_model (
	// serial lines
	output logic scl,
	output logic sda_low,
	// resolved data wire
	input wire logic sda_wire
);
	// clock stands high and data is released between frames
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task start_cond();
		// start off the mclk edge that called us
		#3 sda_low = 1'b1;
		#59 scl = 1'b0;
	endtask

	task put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			#20 sda_low = ~b[i];
			#42 scl = 1'b1;
			#63 scl = 1'b0;
		end
		#20 sda_low = 1'b0;
		#42 scl = 1'b1;
		// sampled late in the high phase: the answer lags the clock
		#60 ack = ~sda_wire;
		#3 scl = 1'b0;
		// stretched low so the ack release lands before the next bit
		#40;
	endtask

	task stop_cond();
		#20 sda_low = 1'b1;
		#42 scl = 1'b1;
		#62 sda_low = 1'b0;
		#62;
	endtask
endmodule // wsap_master_model

`default_nettype wire

// ### test_wsap_top.sv
`timescale 1ns/1ns
`default_nettype none

module test_wsap_top;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic reset_pin_n = 1'b1;
	logic [3:0] pins = 4'ha;
	logic scl, sda_low, sda_out, sda_oe_n, reg_wr_stb;
	logic [6:0] reg_wr_addr;
	logic [7:0] reg_wr_data, pointer_control;
	logic [7:0] mode_exp = 8'h09;
	logic [14:0] wq[$];
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	// open drain with pull-up
	wire sda_wire = ~sda_low & sda_oe_n;

	always #10 mclk = ~mclk;

	wsap_top wsap_top_i (
		.mclk(mclk),
		.reset(reset),
		.reset_pin_n(reset_pin_n),
		.fast_serial_clock_line(scl),
		.fast_serial_data_line(sda_wire),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.addr_select_pin_0(pins[0]),
		.addr_select_pin_1(pins[1]),
		.addr_select_pin_2(pins[2]),
		.addr_select_pin_3(pins[3]),
		.reg_wr_stb(reg_wr_stb),
		.reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data),
		.pointer_control(pointer_control)
	);

	wsap_master_model wsap_master_model_i (
		.scl(scl),
		.sda_low(sda_low),
		.sda_wire(sda_wire)
	);

	task end_of_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (reg_wr_stb === 1'b1)
			wq.push_back({reg_wr_addr, reg_wr_data});
		if (cycles == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	task chk(input string nm, input logic [14:0] seen, input logic [14:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function logic [6:0] step(input logic [6:0] p, input logic f);
		case ({f, mode_exp[6:5]})
			3'b100: step = (p == 7'h41) ? 7'h00 : p + 7'h01;
			3'b101: step = (p == 7'h19) ? 7'h0a : p + 7'h01;
			3'b110: step = (p == 7'h31) ? 7'h00 : p + 7'h01;
			3'b111: step = (p == 7'h19) ? 7'h08 : p + 7'h01;
			default: step = p;
		endcase
	endfunction

	function logic used(input logic [6:0] p);
		used = !(p inside {[7'h06:7'h07], [7'h1a:7'h21]}) && p <= 7'h41;
	endfunction

	task automatic frame(input logic [7:0] adr, input logic [7:0] ctl,
		input int n,
		input logic [23:0] d, input logic ack_exp);
		logic ack;
		logic [6:0] p;
		logic [6:0] nxt;
		logic [7:0] b;
		logic [14:0] q[$];
		p = ctl[6:0];
		q.delete();
		wq.delete();
		wsap_master_model_i.start_cond();
		wsap_master_model_i.put_byte(adr, ack);
		chk("addr_ack", ack, ack_exp);
		if (ack_exp)
		begin
			wsap_master_model_i.put_byte(ctl, ack);
			chk("ctrl_ack", ack, 1'b1);
			for (int i = 0; i < n; i++)
			begin
				b = d[23 - 8 * i -: 8];
				wsap_master_model_i.put_byte(b, ack);
				chk("data_ack", ack, 1'b1);
				if (used(p))
					q.push_back({p, b});
				nxt = step(p, ctl[7]);
				if (p == 7'h00)
					mode_exp = b;
				p = nxt;
			end
		end
		wsap_master_model_i.stop_cond();
		repeat (8) @(posedge mclk);
		chk("wr_count", 15'(wq.size()), 15'(q.size()));
		foreach (q[k])
			if (k < wq.size())
				chk("wr_addr_data", wq[k], q[k]);
		if (ack_exp)
			chk("pointer_control", pointer_control, {ctl[7], p});
	endtask

	initial
	begin
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("pointer_control", pointer_control, 8'h80);
		chk("sda_oe_n", sda_oe_n, 1'b1);
		chk("sda_out", sda_out, 1'b0);
		frame(8'hb4, 8'h02, 3, 24'h11_2233, 1'b1);
		frame(8'hb5, 8'h00, 0, 24'h00_0000, 1'b0);
		pins <= 4'h3;
		repeat (4) @(posedge mclk);
		frame(8'hb4, 8'h00, 0, 24'h00_0000, 1'b0);
		frame(8'ha6, 8'h03, 1, 24'h77_0000, 1'b1);
		frame(8'he0, 8'h3f, 1, 24'hd0_0000, 1'b1);
		frame(8'hec, 8'h00, 0, 24'h00_0000, 1'b0);
		frame(8'hd0, 8'h01, 1, 24'h55_0000, 1'b1);
		frame(8'ha6, 8'hc1, 2, 24'hec_2900, 1'b1);
		frame(8'ha6, 8'h98, 3, 24'h01_0203, 1'b1);
		frame(8'ha6, 8'h80, 1, 24'h49_0000, 1'b1);
		frame(8'ha6, 8'h99, 3, 24'h04_0506, 1'b1);
		frame(8'ha6, 8'hb1, 2, 24'h07_6900, 1'b1);
		frame(8'ha6, 8'h99, 2, 24'h0a_0b00, 1'b1);
		reset_pin_n <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("pointer_control", pointer_control, 8'h80);
		reset_pin_n <= 1'b1;
		mode_exp = 8'h09;
		repeat (8) @(posedge mclk);
		frame(8'he0, 8'h85, 2, 24'h0c_0d00, 1'b1);
		end_of_test();
	end
endmodule // test_wsap_top

`default_nettype wire
